// >>> rtl/snv_host.sv
// Host end: command FIFO and serial master for the memory link
`timescale 1ns/1ps
`include "snv_defs.svh"
module snv_fifo #(
    parameter int W = 9,
    parameter int D = `SNV_FIFO_DEPTH
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wp_q;
    logic [AW:0]  rp_q;

    assign in_ready  = (wp_q - rp_q) != (AW + 1)'(D);
    assign out_valid = wp_q != rp_q;
    assign out_data  = mem[rp_q[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp_q <= wp_q + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (in_valid && in_ready) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule // snv_fifo

module snv_host (
    input  wire logic       mclk,
    input  wire logic       rst,
    snv_if.host             bus,
    input  wire logic [7:0] cmd_data,
    input  wire logic       cmd_last,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    output logic [7:0]      rsp_data,
    output logic            rsp_valid,
    input  wire logic       hold_req,
    input  wire logic       wp_req,
    output logic            busy
);
    import snv_pkg::*;

    localparam logic [7:0] HALF = 8'(`SNV_SCK_HALF);
    localparam logic [7:0] GAP  = 8'(`SNV_GAP_CYC);

    snv_host_t  q;
    snv_host_t  d;
    logic [8:0] f_data;
    logic       f_valid;
    logic       pop;
    logic       held;
    logic [7:0] rx_n;

    snv_fifo #(.W(9), .D(`SNV_FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_data   ({cmd_last, cmd_data}),
        .in_valid  (cmd_valid),
        .in_ready  (cmd_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (pop)
    );

    assign held = ~q.hold_n;
    assign rx_n = {q.rx[6:0], q.miso_s[1]}; // RULE14

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d          = q;
        pop        = 1'b0;
        d.miso_s   = {q.miso_s[0], bus.miso};
        d.rx_valid = 1'b0;
        d.wp_n     = ~wp_req; // RULE7
        case (q.st)
            H_IDLE, H_WAIT: begin
                if (f_valid && !held) begin
                    pop    = 1'b1;
                    d.cs_n = 1'b0; // RULE2
                    d.tx   = f_data[7:0];
                    d.last = f_data[8];
                    d.mosi = f_data[7];
                    d.cnt  = 3'h0;
                    d.div  = 8'h00;
                    d.st   = H_LOW;
                end
            end
            H_LOW: begin
                if (!held) begin // RULE5
                    if (q.div == HALF - 8'h01) begin
                        d.div = 8'h00;
                        d.sck = 1'b1; // RULE12
                        d.st  = H_HIGH;
                    end else begin
                        d.div = q.div + 8'h01;
                    end
                end
            end
            H_HIGH: begin
                if (q.div == HALF - 8'h01) begin // RULE4
                    d.div = 8'h00;
                    d.sck = 1'b0;
                    d.rx  = rx_n;
                    if (q.cnt == 3'h7) begin
                        d.rx_valid = 1'b1;
                        d.rx_data  = rx_n;
                        d.cs_n     = q.last;
                        d.st       = q.last ? H_GAP : H_WAIT;
                    end else begin
                        d.cnt  = q.cnt + 3'h1;
                        d.tx   = {q.tx[6:0], 1'b0};
                        d.mosi = q.tx[6]; // RULE14
                        d.st   = H_LOW;
                    end
                end else begin
                    d.div = q.div + 8'h01;
                end
            end
            H_GAP: begin
                if (q.div == GAP - 8'h01) begin
                    d.div = 8'h00;
                    d.st  = H_IDLE;
                end else begin
                    d.div = q.div + 8'h01;
                end
            end
            default: d.st = H_IDLE;
        endcase
        // Suspend moves only while the clock stays low across the edge
        if (!q.sck && !d.sck) begin
            d.hold_n = ~hold_req; // RULE6
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q        <= '0;
            q.miso_s <= 2'h3;
            q.st     <= H_IDLE;
            q.cs_n   <= 1'b1;
            q.hold_n <= 1'b1;
            q.wp_n   <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus.sck    = q.sck;
    assign bus.cs_n   = q.cs_n;
    assign bus.mosi   = q.mosi;
    assign bus.hold_n = q.hold_n;
    assign bus.wp_n   = q.wp_n;
    assign rsp_data   = q.rx_data;
    assign rsp_valid  = q.rx_valid;
    assign busy       = q.st != H_IDLE;
endmodule // snv_host

// >>> common/snv_defs.svh
// Constants of the serial nonvolatile byte memory link
`ifndef SNV_DEFS_SVH
`define SNV_DEFS_SVH

// ----------------------------------------------------------------------
// Op-codes
// ----------------------------------------------------------------------
`define SNV_OP_SET_WL     8'h06
`define SNV_OP_CLR_WL     8'h04
`define SNV_OP_RD_STAT    8'h05
`define SNV_OP_WR_STAT    8'h01
`define SNV_OP_RD_LO      3'h3
`define SNV_OP_WR_LO      3'h2
`define SNV_OP_A8_POS     3

// ----------------------------------------------------------------------
// Status byte layout, reset value and protection bounds
// ----------------------------------------------------------------------
`define SNV_ST_WEL_POS    1
`define SNV_ST_BP_POS     2
`define SNV_BP_RST        2'h0
`define SNV_PROT_QTR      9'h180
`define SNV_PROT_HALF     9'h100

// ----------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------
`define SNV_ADDR_W        9
`define SNV_MEM_DEPTH     512
`define SNV_FIFO_DEPTH    16
`define SNV_CLK_NS        8
`define SNV_SCK_MAX_KHZ   14000
`define SNV_SCK_HALF      ((1000000 + 2 * `SNV_SCK_MAX_KHZ * `SNV_CLK_NS - 1) \
                           / (2 * `SNV_SCK_MAX_KHZ * `SNV_CLK_NS))
`define SNV_GAP_CYC       (2 * `SNV_SCK_HALF)

`endif

// >>> common/snv_pkg.sv
// Types shared by both ends of the serial memory link
package snv_pkg;
`include "snv_defs.svh"

    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_OP   = 3'h1,
        D_ADDR = 3'h3,
        D_RD   = 3'h2,
        D_WR   = 3'h6,
        D_SRD  = 3'h7,
        D_SWR  = 3'h5,
        D_IGN  = 3'h4
    } snv_dst_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_WAIT = 3'h1,
        H_LOW  = 3'h3,
        H_HIGH = 3'h2,
        H_GAP  = 3'h6
    } snv_hst_t;

    typedef struct packed {
        logic [1:0]             cs_s;
        logic [2:0]             sck_s;
        logic [1:0]             mosi_s;
        logic [1:0]             hold_s;
        logic [1:0]             wp_s;
        snv_dst_t               st;
        logic                   cs_act;
        logic [2:0]             cnt;
        logic [7:0]             rx;
        logic [7:0]             tx;
        logic [`SNV_ADDR_W-1:0] addr;
        logic                   a8;
        logic                   rd;
        logic                   write_latch_flag;
        logic [1:0]             bp;
        logic                   wrote;
        logic                   miso;
        logic                   oe;
    } snv_dev_t;

    typedef struct packed {
        logic [1:0] miso_s;
        snv_hst_t   st;
        logic [7:0] div;
        logic [2:0] cnt;
        logic [7:0] tx;
        logic [7:0] rx;
        logic       last;
        logic       cs_n;
        logic       sck;
        logic       mosi;
        logic       hold_n;
        logic       wp_n;
        logic       rx_valid;
        logic [7:0] rx_data;
    } snv_host_t;

endpackage

// >>> common/snv_if.sv
// Pins of the serial memory link between host and device
`timescale 1ns/1ps
interface snv_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic hold_n;
    logic wp_n;
    logic miso_o;
    logic miso_oe;
    logic miso;

    // Undriven data line rests high, as with a pull-up
    assign miso = miso_oe ? miso_o : 1'b1;

    modport dev (
        input  sck, cs_n, mosi, hold_n, wp_n,
        output miso_o, miso_oe
    );

    modport host (
        output sck, cs_n, mosi, hold_n, wp_n,
        input  miso
    );
endinterface

// >>> rtl/snv_dev.sv
// Device end: serial slave port and 512 x 8 byte memory
// Notes on behaviour
// RULE1 - Deselected: standby, ignore inputs, output released
// RULE2 - Op-code interpreted only after select falls
// RULE3 - Sample on clock rise, shift out on fall
// RULE4 - Static logic; clock may stop any time
// RULE5 - Suspend low freezes everything, ignores clock, select
// RULE6 - Host toggles suspend only while clock low
// RULE7 - Write-protect low refuses all writes
// RULE8 - Data output driven only while returning data
// RULE9 - Ninth address bit comes from op-code
// RULE10 - Writes finish within transfer, never busy
// RULE11 - Reset puts control logic in idle
// RULE12 - Clock modes 0 and 3 only
// RULE13 - First byte is op-code, six encodings
// RULE14 - Bytes of eight bits, MSB first
// RULE15 - Write latch: set, clear, cleared after writes
// RULE16 - Protect bits guard upper quarter, half, all
// RULE17 - Address byte then data, incrementing, wrapping
`timescale 1ns/1ps
`include "snv_defs.svh"
module snv_dev (
    input  wire logic                mclk,
    input  wire logic                rst,
    snv_if.dev                       bus,
    output logic                     sel_o,
    output logic [7:0]               status_o
);
    import snv_pkg::*;

    snv_dev_t               q;
    snv_dev_t               d;
    logic [7:0]             mem [`SNV_MEM_DEPTH];
    logic                   mem_we;
    logic [`SNV_ADDR_W-1:0] mem_wa;
    logic [7:0]             mem_wd;
    logic                   rise;
    logic                   fall;
    logic                   run;
    logic [7:0]             byte_in;
    logic [`SNV_ADDR_W-1:0] ad;

    function automatic logic [7:0] stat(input logic wl, input logic [1:0] b);
        logic [7:0] s;
        s = 8'h00;
        s[`SNV_ST_WEL_POS] = wl;
        s[`SNV_ST_BP_POS +: 2] = b;
        return s;
    endfunction

    function automatic logic prot(input logic [`SNV_ADDR_W-1:0] a,
                                  input logic [1:0] b);
        case (b)
            2'h1:    return a >= `SNV_PROT_QTR; // RULE16
            2'h2:    return a >= `SNV_PROT_HALF; // RULE16
            2'h3:    return 1'b1; // RULE16
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Pin sampling and edges
    // ------------------------------------------------------------------
    assign rise    = q.sck_s[1] & ~q.sck_s[2]; // RULE3
    assign fall    = ~q.sck_s[1] & q.sck_s[2]; // RULE3
    assign run     = q.hold_s[1];
    assign byte_in = {q.rx[6:0], q.mosi_s[1]}; // RULE14

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d        = q;
        ad       = {q.a8, byte_in}; // RULE9
        mem_we   = 1'b0;
        mem_wa   = q.addr;
        mem_wd   = byte_in;
        d.cs_s   = {q.cs_s[0], bus.cs_n};
        d.sck_s  = {q.sck_s[1:0], bus.sck};
        d.mosi_s = {q.mosi_s[0], bus.mosi};
        d.hold_s = {q.hold_s[0], bus.hold_n};
        d.wp_s   = {q.wp_s[0], bus.wp_n};
        if (run) begin // RULE5
            if (q.cs_s[1]) begin
                if (q.cs_act && q.wrote) begin
                    d.write_latch_flag = 1'b0; // RULE15
                end
                d.cs_act = 1'b0; // RULE1
                d.st     = D_IDLE;
                d.oe     = 1'b0;
                d.wrote  = 1'b0;
            end else if (!q.cs_act) begin
                d.cs_act = 1'b1; // RULE2
                d.st     = D_OP;
                d.cnt    = 3'h0;
            end else if (rise) begin // RULE12
                d.rx  = byte_in;
                d.cnt = q.cnt + 3'h1;
                if (q.cnt == 3'h7) begin
                    case (q.st)
                        D_OP: begin // RULE13
                            if (byte_in == `SNV_OP_SET_WL) begin
                                d.write_latch_flag = 1'b1; // RULE15
                                d.st  = D_IGN;
                            end else if (byte_in == `SNV_OP_CLR_WL) begin
                                d.write_latch_flag = 1'b0; // RULE15
                                d.st  = D_IGN;
                            end else if (byte_in == `SNV_OP_RD_STAT) begin
                                d.tx = stat(q.write_latch_flag, q.bp);
                                d.st = D_SRD;
                            end else if (byte_in == `SNV_OP_WR_STAT) begin
                                d.st    = D_SWR;
                                d.wrote = 1'b1;
                            end else if (byte_in[7:4] == 4'h0 &&
                                         byte_in[2:0] == `SNV_OP_RD_LO) begin
                                d.a8 = byte_in[`SNV_OP_A8_POS]; // RULE9
                                d.rd = 1'b1;
                                d.st = D_ADDR;
                            end else if (byte_in[7:4] == 4'h0 &&
                                         byte_in[2:0] == `SNV_OP_WR_LO) begin
                                d.a8    = byte_in[`SNV_OP_A8_POS]; // RULE9
                                d.rd    = 1'b0;
                                d.wrote = 1'b1;
                                d.st    = D_ADDR;
                            end else begin
                                d.st = D_IGN;
                            end
                        end
                        D_ADDR: begin // RULE17
                            if (q.rd) begin
                                d.tx   = mem[ad];
                                d.addr = ad + 9'h001;
                                d.st   = D_RD;
                            end else begin
                                d.addr = ad;
                                d.st   = D_WR;
                            end
                        end
                        D_RD: begin
                            d.tx   = mem[q.addr];
                            d.addr = q.addr + 9'h001; // RULE17
                        end
                        D_WR: begin
                            mem_we = q.write_latch_flag && q.wp_s[1] &&
                                     !prot(q.addr, q.bp); // RULE7 RULE10
                            d.addr = q.addr + 9'h001; // RULE17
                        end
                        D_SWR: begin
                            if (q.write_latch_flag && q.wp_s[1]) begin // RULE7
                                d.bp = byte_in[`SNV_ST_BP_POS +: 2];
                            end
                            d.st = D_IGN;
                        end
                        D_SRD: d.tx = stat(q.write_latch_flag, q.bp);
                        default: ;
                    endcase
                end
            end else if (fall && (q.st == D_RD || q.st == D_SRD)) begin
                d.miso = q.tx[7]; // RULE3 RULE14
                d.tx   = {q.tx[6:0], 1'b0};
                d.oe   = 1'b1; // RULE8
            end
        end
    end

    // ------------------------------------------------------------------
    // State registers and memory
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin // RULE11
            q        <= '0;
            q.cs_s   <= 2'h3;
            q.hold_s <= 2'h3;
            q.wp_s   <= 2'h3;
            q.st     <= D_IDLE;
            q.bp     <= `SNV_BP_RST;
        end else begin
            q <= d; // RULE4
        end
    end

    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd; // RULE10
        end
    end

    assign bus.miso_o  = q.miso;
    assign bus.miso_oe = q.oe & run; // RULE8
    assign sel_o       = q.cs_act;
    assign status_o    = stat(q.write_latch_flag, q.bp);
endmodule // snv_dev

// >>> tb/snv_props.sv
// Concurrent checks on the pins of the serial memory link
`timescale 1ns/1ps
module snv_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Output enable
    // ------------------------------------------------------------------
    chk_idle_released: assert property (
        cs_n [*5] |-> !miso_oe) else $error("output driven while idle");
    chk_hold_released: assert property (
        (!hold_n) [*5] |-> !miso_oe) else $error("output driven in hold");
    chk_oe_start: assert property (
        $rose(miso_oe) && $past(hold_n, 3) |-> !cs_n && hold_n && !sck)
        else $error("output enabled at wrong time");
    chk_out_on_fall: assert property (
        miso_oe && $changed(miso_o) |-> !sck)
        else $error("output changed while clock high");

    // ------------------------------------------------------------------
    // Host framing and clock
    // ------------------------------------------------------------------
    chk_in_stable: assert property (
        sck && $past(sck) |-> $stable(mosi) && $stable(cs_n))
        else $error("input moved while clock high");
    chk_hold_sck_low: assert property (
        $changed(hold_n) |-> !sck) else $error("hold moved with clock high");
    chk_sck_high_len: assert property (
        $rose(sck) |-> sck [*5] ##1 !sck) else $error("clock high length");
    chk_sck_low_len: assert property (
        $fell(sck) |-> (!sck) [*5]) else $error("clock low too short");
    chk_gap_len: assert property (
        $rose(cs_n) |-> cs_n [*8] ##1 cs_n [*2])
        else $error("deselect gap too short");
    chk_mode_idle: assert property (
        cs_n |-> !sck) else $error("clock not idle low");
    chk_first_rise: assert property (
        $fell(cs_n) |-> (!sck) [*5] ##1 sck)
        else $error("first clock rise misplaced");
endmodule // snv_props

// >>> tb/tb_top.sv
// Bench joining host and device ends of the serial memory link
`timescale 1ns/1ps
module tb_top;
    logic       mclk;
    logic       rst;
    logic [7:0] cmd_data;
    logic       cmd_last;
    logic       cmd_valid;
    logic       cmd_ready;
    logic [7:0] rsp_data;
    logic       rsp_valid;
    logic       hold_req;
    logic       wp_req;
    logic       busy;
    logic       sel;
    logic [7:0] status;
    logic [7:0] rsp_q [$];
    logic [7:0] model [512];
    logic [8:0] addrs [6];
    int         num_errors;
    int         tests_run;

    snv_if bus_if ();
    snv_dev u_snv_dev (.mclk(mclk), .rst(rst), .bus(bus_if),
        .sel_o(sel), .status_o(status));
    snv_host u_snv_host (.mclk(mclk), .rst(rst), .bus(bus_if),
        .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .hold_req(hold_req), .wp_req(wp_req), .busy(busy));
    snv_props u_snv_props (.mclk(mclk), .rst(rst), .sck(bus_if.sck),
        .cs_n(bus_if.cs_n), .mosi(bus_if.mosi), .hold_n(bus_if.hold_n),
        .wp_n(bus_if.wp_n), .miso_o(bus_if.miso_o),
        .miso_oe(bus_if.miso_oe), .miso(bus_if.miso));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic push(input logic [7:0] d, input logic l);
        @(negedge mclk);
        cmd_data = d;
        cmd_last = l;
        cmd_valid = 1'b1;
        for (int k = 0; k < 3000 && cmd_ready !== 1'b1; k++) @(negedge mclk);
        if (cmd_ready !== 1'b1) begin
            num_errors++;
            stop_test();
        end
        @(posedge mclk);
    endtask

    task automatic wait_done(input int n);
        @(negedge mclk);
        cmd_valid = 1'b0;
        for (int k = 0; k < 3000; k++) begin
            if (rsp_q.size() >= n && busy === 1'b0) return;
            @(negedge mclk);
        end
        num_errors++;
        stop_test();
    endtask

    task automatic frame(input int n, input logic [7:0] b0,
        input logic [7:0] b1 = 8'h00, input logic [7:0] b2 = 8'h00,
        input logic [7:0] b3 = 8'h00);
        logic [7:0] b [4];
        b = '{b0, b1, b2, b3};
        rsp_q = {};
        for (int i = 0; i < n; i++) push(b[i], i == n - 1);
        wait_done(n);
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        frame(1, 8'h06);
        frame(3, {4'h0, a[8], 3'h2}, a[7:0], v);
    endtask

    task automatic rd(input logic [8:0] a);
        frame(3, {4'h0, a[8], 3'h3}, a[7:0]);
    endtask

    task automatic set_bp(input logic [1:0] bp);
        frame(1, 8'h06);
        frame(2, 8'h01, {4'h0, bp, 2'h0});
        check(status, {4'h0, bp, 2'h0});
        frame(2, 8'h05);
        check(rsp_q[1], {4'h0, bp, 2'h0});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check(status, 8'h00);
        check({6'h0, sel, bus_if.miso_oe}, 8'h00);
        check({7'h0, bus_if.cs_n}, 8'h01);
    endtask

    task automatic t_latch();
        frame(1, 8'h06);
        check(status, 8'h02);
        frame(1, 8'h04);
        check(status, 8'h00);
    endtask

    task automatic t_burst();
        frame(1, 8'h06);
        frame(4, 8'h0a, 8'hff, 8'h11, 8'h22);
        check(status, 8'h00);
        frame(4, 8'h0b, 8'hff);
        check(rsp_q[2], 8'h11);
        check(rsp_q[3], 8'h22);
        frame(3, 8'h02, 8'h00, 8'hee);
        rd(9'h000);
        check(rsp_q[2], 8'h22);
    endtask

    task automatic t_protect();
        logic pr;
        logic [7:0] v;
        addrs = '{9'h0ff, 9'h100, 9'h17f, 9'h180, 9'h1ff, 9'h000};
        for (int bp = 0; bp < 4; bp++) begin
            set_bp(bp[1:0]);
            for (int i = 0; i < 6; i++) begin
                v = {bp[1:0], i[5:0]};
                pr = bp == 3 || (bp == 2 && addrs[i] >= 9'h100)
                    || (bp == 1 && addrs[i] >= 9'h180);
                wr(addrs[i], v);
                if (!pr) model[addrs[i]] = v;
                rd(addrs[i]);
                check(rsp_q[2], model[addrs[i]]);
            end
        end
        set_bp(2'h0);
        for (int i = 0; i < 6; i++) begin
            rd(addrs[i]);
            check(rsp_q[2], model[addrs[i]]);
        end
    endtask

    task automatic t_wp();
        wp_req = 1'b1;
        wr(9'h0ff, 8'h5e);
        rd(9'h0ff);
        check(rsp_q[2], model[9'h0ff]);
        frame(1, 8'h06);
        frame(2, 8'h01, 8'h0c);
        check(status, 8'h00);
        wp_req = 1'b0;
    endtask

    task automatic t_hold();
        fork
            frame(4, 8'h03, 8'hff);
            begin
                repeat (250) @(negedge mclk);
                hold_req = 1'b1;
                repeat (40) @(negedge mclk);
                check({6'h0, bus_if.hold_n, bus_if.miso_oe}, 8'h00);
                hold_req = 1'b0;
            end
        join
        check(rsp_q[2], model[9'h0ff]);
        check(rsp_q[3], model[9'h100]);
    endtask

    task automatic t_fill();
        int cnt;
        cnt = 0;
        rsp_q = {};
        hold_req = 1'b1;
        for (int k = 0; k < 20; k++) begin
            @(negedge mclk);
            if (cmd_ready !== 1'b1) break;
            cmd_valid = 1'b1;
            cmd_data = (k == 0) ? 8'h05 : 8'h00;
            cmd_last = 1'b0;
            cnt++;
        end
        cmd_valid = 1'b0;
        check({7'h0, cnt >= 16 && cnt <= 17}, 8'h01);
        hold_req = 1'b0;
        push(8'h00, 1'b1);
        wait_done(cnt + 1);
        check(rsp_q[cnt], 8'h00);
    endtask

    initial begin
        rst = 1'b1;
        cmd_data = 8'h00;
        cmd_last = 1'b0;
        cmd_valid = 1'b0;
        hold_req = 1'b0;
        wp_req = 1'b0;
        num_errors = 0;
        tests_run = 0;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        t_reset();
        t_latch();
        t_burst();
        t_protect();
        t_wp();
        t_hold();
        t_fill();
        stop_test();
    end
endmodule // tb_top
